// File: rtl/sci_defs.svh
// constants for the serial radio command interpreter
`ifndef SCI_DEFS_SVH
`define SCI_DEFS_SVH

// frame bytes
`define SCI_PREFIX       8'hFE
`define SCI_TERM         8'hFD
`define SCI_OK           8'hFB
`define SCI_NG           8'hFA
`define SCI_HOST_ADDR    8'hE0
`define SCI_BCAST_ADDR   8'h00

// command codes
`define SCI_CMD_SETMODE  8'h06
`define SCI_CMD_SELCH    8'h08
`define SCI_CMD_STORE    8'h09
`define SCI_CMD_LOAD     8'h0A
`define SCI_CMD_WROFS    8'h0D
`define SCI_CMD_SPLIT    8'h0F
`define SCI_CMD_RDOFS    8'h9C
`define SCI_TRK_FREQ     8'h00
`define SCI_TRK_MODE     8'h01
`define SCI_SPLIT_OFF    8'h00
`define SCI_SPLIT_ON     8'h01

// limits
`define SCI_MODE_MAX     8'h07
`define SCI_CHAN_MAX     7'h1F
`define SCI_NCHAN        32
`define SCI_DBUF_MAX     3'h4

// frame lengths in bytes
`define SCI_LEN_ACK      4'h6
`define SCI_LEN_OFS      4'h7
`define SCI_LEN_BCF      4'hA
`define SCI_LEN_BCM      4'h7
`define SCI_FRAME_MAX    10

// register byte addresses
`define SCI_REG_CTRL     8'h00
`define SCI_REG_FREQ     8'h04
`define SCI_REG_MODE     8'h08
`define SCI_REG_STATUS   8'h0C

// register fields
`define SCI_CTRL_TRK     0
`define SCI_CTRL_ADDR    15:8
`define SCI_STAT_SPLIT   0
`define SCI_STAT_CHAN    12:8
`define SCI_STAT_OFS     31:16

// reset values
`define SCI_OWN_ADDR_RST 8'h04
`define SCI_FREQ_RST     32'h0000_0000
`define SCI_MODE_RST     8'h00
`define SCI_OFS_RST      16'h0000

`endif

// File: rtl/sci_pkg.sv
// types for the serial radio command interpreter
`default_nettype none
package sci_pkg;

  typedef enum logic [2:0] {
    SCI_IDLE  = 3'b000,
    SCI_PRE   = 3'b001,
    SCI_RADDR = 3'b011,
    SCI_SADDR = 3'b010,
    SCI_CMD   = 3'b110,
    SCI_DATA  = 3'b111
  } sci_state_t;

  typedef enum logic [2:0] {
    SCI_FR_NONE = 3'b000,
    SCI_FR_ACK  = 3'b001,
    SCI_FR_OFS  = 3'b011,
    SCI_FR_BCF  = 3'b010,
    SCI_FR_BCM  = 3'b110
  } sci_frame_t;

endpackage : sci_pkg
`default_nettype wire

// File: rtl/sci_bcd_byte.sv
// checker and converter for one packed two-digit bcd byte
`default_nettype none
module sci_bcd_byte (
  input  wire logic [7:0] byte_in,
  output logic            ok,
  output logic [6:0]      bin
);
  logic [6:0] hi;
  logic [6:0] lo;

  assign hi  = {3'h0, byte_in[7:4]};
  assign lo  = {3'h0, byte_in[3:0]};
  assign ok  = (byte_in[7:4] <= 4'h9) && (byte_in[3:0] <= 4'h9);
  assign bin = (hi << 3) + (hi << 1) + lo;
endmodule : sci_bcd_byte
`default_nettype wire

// File: rtl/sci_interp.sv
// serial radio command interpreter with apb control registers
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "sci_defs.svh"
`default_nettype none
module sci_interp (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  output logic [7:0]       tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready
);
  import sci_pkg::*;

  sci_state_t  state;
  sci_frame_t  fr_kind;
  logic [7:0]  raddr;
  logic [7:0]  cmd;
  logic [7:0]  dbuf [0:3];
  logic [2:0]  dlen;
  logic        dovf;
  logic        exec_pend;
  logic        next_exec_pend;
  logic        tracking;
  logic [7:0]  own_addr;
  logic [31:0] vfo_freq;
  logic [7:0]  vfo_mode;
  logic        bc_freq;
  logic        bc_mode;
  logic [39:0] mem [0:`SCI_NCHAN-1];
  logic [39:0] mem_rd;
  logic [4:0]  sel_chan;
  logic        split;
  logic [15:0] offset;
  logic [7:0]  tx_shift [0:`SCI_FRAME_MAX-1];
  logic [7:0]  nf [0:`SCI_FRAME_MAX-1];
  logic [3:0]  tx_left;
  logic [3:0]  nlen;
  logic [3:0]  bcd_ok;
  logic [6:0]  bcd_bin [0:3];
  logic        rx_fire;
  logic        frame_end;
  logic        exec_go;
  logic        to_me;
  logic        to_bc;
  logic        do_cmd;
  logic        do_trk;
  logic        nodata;
  logic        cmd_ok;
  logic        trk_freq;
  logic        trk_mode;
  logic        load_ok;
  logic        mode_ok;
  logic        own_freq_chg;
  logic        own_mode_chg;
  logic        bc_go;
  logic        apb_setup;
  logic        apb_wr;
  logic        apb_wr_freq;
  logic        apb_wr_mode;
  logic        apb_wr_ctrl;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  // ***************************************************************
  // bcd checkers on the data bytes
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_bcd
      sci_bcd_byte u_bcd (
        .byte_in (dbuf[g]),
        .ok      (bcd_ok[g]),
        .bin     (bcd_bin[g])
      );
    end
  endgenerate

  // ***************************************************************
  // frame receiver
  // ***************************************************************
  assign rx_fire   = rx_valid && rx_ready;
  assign frame_end = rx_fire && (rx_byte == `SCI_TERM) &&
                     (state == SCI_DATA);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= SCI_IDLE;
      raddr <= 8'h00;
      cmd   <= 8'h00;
      dlen  <= 3'h0;
      dovf  <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        dbuf[i] <= 8'h00;
      end
    end
    else if (rx_fire)
    begin
      if (rx_byte == `SCI_PREFIX)
      begin
        // a prefix mid-frame restarts the frame
        if (state == SCI_PRE || state == SCI_RADDR)
          state <= SCI_RADDR;
        else
          state <= SCI_PRE;
      end
      else if (rx_byte == `SCI_TERM)
      begin
        state <= SCI_IDLE;
      end
      else
      begin
        unique case (state)
          SCI_IDLE:  state <= SCI_IDLE;
          SCI_PRE:   state <= SCI_IDLE;
          SCI_RADDR:
          begin
            raddr <= rx_byte;
            state <= SCI_SADDR;
          end
          SCI_SADDR: state <= SCI_CMD;
          SCI_CMD:
          begin
            cmd   <= rx_byte;
            dlen  <= 3'h0;
            dovf  <= 1'b0;
            state <= SCI_DATA;
          end
          SCI_DATA:
          begin
            if (dlen < `SCI_DBUF_MAX)
            begin
              dbuf[dlen[1:0]] <= rx_byte;
              dlen            <= dlen + 3'h1;
            end
            else
              dovf <= 1'b1;
          end
          default:   state <= SCI_IDLE;
        endcase
      end
    end
  end

  // frame waits here until the transmitter is free
  always_comb
  begin
    next_exec_pend = exec_pend;
    if (exec_go)
      next_exec_pend = 1'b0;
    else if (frame_end)
      next_exec_pend = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exec_pend <= 1'b0;
      rx_ready  <= 1'b0;
    end
    else
    begin
      exec_pend <= next_exec_pend;
      rx_ready  <= !next_exec_pend;
    end
  end

  // ***************************************************************
  // command decode
  // ***************************************************************
  assign exec_go = exec_pend && !tx_valid;
  assign to_me   = raddr == own_addr;
  assign to_bc   = tracking && (raddr == `SCI_BCAST_ADDR);
  assign do_cmd  = exec_go && to_me;
  assign do_trk  = exec_go && to_bc && !to_me;
  assign nodata  = (dlen == 3'h0) && !dovf;
  assign mode_ok = !dovf && (dlen == 3'h1 || dlen == 3'h2) &&
                   (dbuf[0] <= `SCI_MODE_MAX);
  assign mem_rd  = mem[sel_chan];

  always_comb
  begin
    unique case (cmd)
      `SCI_CMD_SETMODE: cmd_ok = mode_ok;
      `SCI_CMD_SELCH:   cmd_ok = !dovf && (dlen == 3'h1) && bcd_ok[0] &&
                                 (bcd_bin[0] <= `SCI_CHAN_MAX);
      `SCI_CMD_STORE:   cmd_ok = nodata;
      `SCI_CMD_LOAD:    cmd_ok = nodata;
      `SCI_CMD_SPLIT:   cmd_ok = !dovf && (dlen == 3'h1) &&
                                 (dbuf[0] == `SCI_SPLIT_OFF ||
                                  dbuf[0] == `SCI_SPLIT_ON);
      `SCI_CMD_WROFS:   cmd_ok = !dovf && (dlen == 3'h2) &&
                                 bcd_ok[0] && bcd_ok[1];
      `SCI_CMD_RDOFS:   cmd_ok = nodata;
      default:          cmd_ok = 1'b0;
    endcase
  end

  assign trk_freq = do_trk && (cmd == `SCI_TRK_FREQ) && !dovf &&
                    (dlen == `SCI_DBUF_MAX) && (&bcd_ok);
  assign trk_mode = do_trk && (cmd == `SCI_TRK_MODE) && !dovf &&
                    (dlen == 3'h1);
  assign load_ok  = do_cmd && (cmd == `SCI_CMD_LOAD) && cmd_ok;
  assign own_freq_chg = apb_wr_freq || load_ok;
  assign own_mode_chg = apb_wr_mode || load_ok ||
                        (do_cmd && (cmd == `SCI_CMD_SETMODE) && cmd_ok);

  // ***************************************************************
  // radio state: vfo, memories, channel, split, offset
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vfo_freq <= `SCI_FREQ_RST;
      vfo_mode <= `SCI_MODE_RST;
    end
    else if (load_ok)
    begin
      vfo_freq <= mem_rd[39:8];
      vfo_mode <= mem_rd[7:0];
    end
    else if (trk_freq)
    begin
      vfo_freq <= {dbuf[3], dbuf[2], dbuf[1], dbuf[0]};
    end
    else if (trk_mode)
    begin
      vfo_mode <= dbuf[0];
    end
    else if (do_cmd && (cmd == `SCI_CMD_SETMODE) && cmd_ok)
    begin
      vfo_mode <= dbuf[0];
    end
    else
    begin
      if (apb_wr_freq)
        vfo_freq <= pwdata;
      if (apb_wr_mode)
        vfo_mode <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk)
  begin
    if (do_cmd && (cmd == `SCI_CMD_STORE) && cmd_ok)
      mem[sel_chan] <= {vfo_freq, vfo_mode};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_chan <= 5'h00;
    else if (do_cmd && (cmd == `SCI_CMD_SELCH) && cmd_ok)
      sel_chan <= bcd_bin[0][4:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      split <= 1'b0;
    else if (do_cmd && (cmd == `SCI_CMD_SPLIT) && cmd_ok)
      split <= (dbuf[0] == `SCI_SPLIT_ON);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      offset <= `SCI_OFS_RST;
    else if (do_cmd && (cmd == `SCI_CMD_WROFS) && cmd_ok)
      offset <= {dbuf[1], dbuf[0]};
  end

  // broadcast requests; a new change wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bc_freq <= 1'b0;
      bc_mode <= 1'b0;
    end
    else if (!tracking)
    begin
      bc_freq <= 1'b0;
      bc_mode <= 1'b0;
    end
    else
    begin
      if (own_freq_chg)
        bc_freq <= 1'b1;
      else if (bc_go && bc_freq)
        bc_freq <= 1'b0;
      if (own_mode_chg)
        bc_mode <= 1'b1;
      else if (bc_go && !bc_freq)
        bc_mode <= 1'b0;
    end
  end

  // ***************************************************************
  // frame transmitter
  // ***************************************************************
  assign bc_go = !tx_valid && !do_cmd && (bc_freq || bc_mode);

  always_comb
  begin
    if (do_cmd)
      fr_kind = (cmd == `SCI_CMD_RDOFS && nodata) ? SCI_FR_OFS : SCI_FR_ACK;
    else if (bc_go)
      fr_kind = bc_freq ? SCI_FR_BCF : SCI_FR_BCM;
    else
      fr_kind = SCI_FR_NONE;
  end

  always_comb
  begin
    for (int i = 0; i < `SCI_FRAME_MAX; i++)
    begin
      nf[i] = `SCI_TERM;
    end
    nf[0] = `SCI_PREFIX;
    nf[1] = `SCI_PREFIX;
    nf[2] = `SCI_HOST_ADDR;
    nf[3] = own_addr;
    nlen  = `SCI_LEN_ACK;
    unique case (fr_kind)
      SCI_FR_ACK:
      begin
        nf[4] = cmd_ok ? `SCI_OK : `SCI_NG;
      end
      SCI_FR_OFS:
      begin
        nf[4] = offset[7:0];
        nf[5] = offset[15:8];
        nlen  = `SCI_LEN_OFS;
      end
      SCI_FR_BCF:
      begin
        nf[2] = `SCI_BCAST_ADDR;
        nf[4] = `SCI_TRK_FREQ;
        nf[5] = vfo_freq[7:0];
        nf[6] = vfo_freq[15:8];
        nf[7] = vfo_freq[23:16];
        nf[8] = vfo_freq[31:24];
        nlen  = `SCI_LEN_BCF;
      end
      SCI_FR_BCM:
      begin
        nf[2] = `SCI_BCAST_ADDR;
        nf[4] = `SCI_TRK_MODE;
        nf[5] = vfo_mode;
        nlen  = `SCI_LEN_BCM;
      end
      SCI_FR_NONE: nlen = `SCI_LEN_ACK;
    endcase
  end

  assign tx_byte = tx_shift[0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_valid <= 1'b0;
      tx_left  <= 4'h0;
      for (int i = 0; i < `SCI_FRAME_MAX; i++)
      begin
        tx_shift[i] <= 8'h00;
      end
    end
    else if (!tx_valid)
    begin
      if (fr_kind != SCI_FR_NONE)
      begin
        tx_valid <= 1'b1;
        tx_left  <= nlen;
        for (int i = 0; i < `SCI_FRAME_MAX; i++)
        begin
          tx_shift[i] <= nf[i];
        end
      end
    end
    else if (tx_ready)
    begin
      tx_left  <= tx_left - 4'h1;
      tx_valid <= (tx_left != 4'h1);
      for (int i = 0; i < `SCI_FRAME_MAX - 1; i++)
      begin
        tx_shift[i] <= tx_shift[i+1];
      end
      tx_shift[`SCI_FRAME_MAX-1] <= `SCI_TERM;
    end
  end

  // ***************************************************************
  // apb slave: no wait states, error on unmapped address
  // ***************************************************************
  assign apb_setup   = psel && !penable;
  assign apb_wr      = psel && penable && pready && pwrite;
  assign apb_wr_ctrl = apb_wr && (paddr == `SCI_REG_CTRL);
  assign apb_wr_freq = apb_wr && (paddr == `SCI_REG_FREQ);
  assign apb_wr_mode = apb_wr && (paddr == `SCI_REG_MODE);

  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      `SCI_REG_CTRL:
      begin
        next_prdata[`SCI_CTRL_TRK]  = tracking;
        next_prdata[`SCI_CTRL_ADDR] = own_addr;
      end
      `SCI_REG_FREQ:   next_prdata = vfo_freq;
      `SCI_REG_MODE:   next_prdata[7:0] = vfo_mode;
      `SCI_REG_STATUS:
      begin
        next_prdata[`SCI_STAT_SPLIT] = split;
        next_prdata[`SCI_STAT_CHAN]  = sel_chan;
        next_prdata[`SCI_STAT_OFS]   = offset;
      end
      default:         next_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_setup;
      prdata  <= apb_setup ? next_prdata : 32'h0000_0000;
      pslverr <= apb_setup && next_pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tracking <= 1'b0;
      own_addr <= `SCI_OWN_ADDR_RST;
    end
    else if (apb_wr_ctrl)
    begin
      tracking <= pwdata[`SCI_CTRL_TRK];
      own_addr <= pwdata[`SCI_CTRL_ADDR];
    end
  end

endmodule : sci_interp
`default_nettype wire

// File: testbench/sci_interp_asserts.sv
// port checker for the serial command interpreter
`include "sci_defs.svh"
`default_nettype none
module sci_interp_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  rx_byte,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_valid,
  input wire logic        tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************
  // byte position in outgoing frame
  // ***********************************
  logic [3:0] pos;
  logic [7:0] own;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pos <= 4'h0;
    else if (tx_valid && tx_ready)
      pos <= (tx_byte == `SCI_TERM) ? 4'h0 : pos + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      own <= `SCI_OWN_ADDR_RST;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      own <= pwdata[15:8];
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_PREADY_ONE: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_SLVERR_MAP: assert property (pready |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
    else $error("pslverr wrong");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("tx byte dropped");
  AST_TX_PREFIX: assert property (
    tx_valid && pos < 4'h2 |-> tx_byte == `SCI_PREFIX)
    else $error("bad prefix");
  AST_TX_RCV: assert property (tx_valid && pos == 4'h2 |->
    tx_byte inside {`SCI_HOST_ADDR, `SCI_BCAST_ADDR})
    else $error("bad receiver");
  AST_TX_SENDER: assert property (
    tx_valid && pos == 4'h3 |-> tx_byte == own)
    else $error("bad sender");
  AST_TX_LEN: assert property (tx_valid && tx_ready &&
    tx_byte == `SCI_TERM |-> pos inside {4'h5, 4'h6, 4'h9})
    else $error("bad frame length");
  cover property (tx_valid && tx_ready && tx_byte == `SCI_NG);
  cover property (tx_valid && tx_ready && tx_byte == `SCI_OK);
  cover property (tx_valid && pos == 4'h2 && tx_byte == 8'h00);
endmodule : sci_interp_asserts
bind sci_interp sci_interp_asserts sci_interp_asserts_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_byte(rx_byte),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_byte(tx_byte),
  .tx_valid(tx_valid), .tx_ready(tx_ready)
);
`default_nettype wire

// File: testbench/sci_host_model.sv
// host and peer side model of the serial link
`default_nettype none
module sci_host_model (
  input  wire logic  pclk,
  input  wire logic  rx_ready,
  input  wire logic  slow,
  output logic [7:0] rx_byte,
  output logic       rx_valid,
  output logic       tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int lost = 0;
  initial
  begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // takes replies at once or with random stalls
  always @(posedge pclk)
    tx_ready <= !slow || ($urandom_range(2) == 0);
  // offers a byte and holds it until taken
  task automatic send(input logic [7:0] b);
    int n;
    @(posedge pclk);
    rx_byte <= b;
    rx_valid <= 1'b1;
    for (n = 0; n < 2000; n++)
    begin
      @(posedge pclk);
      if (rx_ready === 1'b1)
        break;
    end
    rx_valid <= 1'b0;
    rx_byte <= ~b;
    if (n == 2000)
      lost++;
  endtask : send
endmodule : sci_host_model
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking testbench for the serial command interpreter
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, slow;
  logic        pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]  paddr, rx_byte, tx_byte, ch, lo, hi;
  logic [31:0] pwdata, prdata, f;
  logic [23:0] tab[$];
  logic [7:0]  txq[$], pq[$];
  logic [32:0] rdq[$], nx;
  int          miscompares = 0, checks = 0;
  sci_interp sci_interp_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  sci_host_model sci_host_model_i (
    .pclk(pclk), .rx_ready(rx_ready), .slow(slow), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .tx_ready(tx_ready));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ***********************************
  // shared tasks
  // ***********************************
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic timeout();
    miscompares++;
    test_done();
  endtask : timeout
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [7:0] rbcd();
    return {4'($urandom_range(9)), 4'($urandom_range(9))};
  endfunction : rbcd
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      rdq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
      timeout();
  endtask : apb
  task automatic want(input logic [7:0] b[$]);
    txq = {txq, b};
  endtask : want
  task automatic ack(input logic [7:0] c);
    want('{8'hFE, 8'hFE, 8'hE0, 8'h04, c, 8'hFD});
  endtask : ack
  task automatic cmd(input logic [7:0] r, s, input logic [7:0] b[$]);
    logic [7:0] q[$];
    int         n;
    q = {8'hFE, 8'hFE, r, s, b, 8'hFD};
    foreach (q[i])
      sci_host_model_i.send(q[i]);
    if (sci_host_model_i.lost != 0)
      timeout();
    for (n = 0; n < 4000 && txq.size() > 0; n++)
      @(posedge pclk);
    if (n == 4000)
      timeout();
    repeat (30)
      @(posedge pclk);
  endtask : cmd
  // compares every sent byte and read word with the oldest note
  always @(posedge pclk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      nx = txq.size() ? {25'h0, txq.pop_front()} : 33'h1_0000_0000;
      cmp({25'h0, tx_byte}, nx);
    end
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp({pslverr, prdata}, rdq.pop_front());
  end
  initial
  begin
    {presetn, psel, penable, pwrite, slow} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'hDE44AFB1));
    repeat (10)
      @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0, 33'h400);
    apb(0, 8'h04, 0, 33'h0);
    apb(1, 8'h0C, 32'hFFFF_FFFF, 0);
    apb(1, 8'h10, 32'h1, 0);
    apb(0, 8'h0C, 0, 33'h0);
    apb(0, 8'h10, 0, 33'h1_0000_0000);
    ch = 8'($urandom_range(31));
    tab = '{24'h0831FB, 24'h0832FA, 24'h081AFA, 24'h0F01FB, 24'h0603FB,
            24'h0607FB, 24'h0608FA, 24'h0F02FA, 24'h0A05FA, 24'h9C01FA,
            24'h1200FA, {8'h08, 4'(ch / 10), 4'(ch % 10), 8'hFB}};
    foreach (tab[i])
    begin
      ack(tab[i][7:0]);
      cmd(8'h04, 8'hE0, '{tab[i][23:16], tab[i][15:8]});
    end
    apb(0, 8'h08, 0, 33'h7);
    apb(0, 8'h0C, 0, {20'h0, ch[4:0], 8'h01});
    f = {rbcd(), rbcd(), rbcd(), rbcd()};
    apb(1, 8'h04, f, 0);
    ack(8'hFB);
    cmd(8'h04, 8'hE0, '{8'h09});
    apb(1, 8'h04, 32'h0, 0);
    ack(8'hFB);
    cmd(8'h04, 8'hE0, '{8'h0A});
    apb(0, 8'h04, 0, {1'b0, f});
    lo = rbcd();
    hi = {4'h9, 4'($urandom_range(9))};
    ack(8'hFB);
    cmd(8'h04, 8'hE0, '{8'h0D, lo, hi});
    want('{8'hFE, 8'hFE, 8'hE0, 8'h04, lo, hi, 8'hFD});
    cmd(8'h04, 8'hE0, '{8'h9C});
    ack(8'hFB);
    cmd(8'h04, 8'hE0, '{8'h0F, 8'h00});
    cmd(8'h05, 8'hE0, '{8'h0F, 8'h01});
    cmd(8'h00, 8'h07, '{8'h0F, 8'h01});
    pq = '{8'hFE, 8'hFE, 8'h04, 8'hE0, 8'h0F, 8'h01};
    foreach (pq[i])
      sci_host_model_i.send(pq[i]);
    if (sci_host_model_i.lost != 0)
      timeout();
    ack(8'hFB);
    cmd(8'h04, 8'hE0, '{8'h06, 8'h02});
    apb(0, 8'h0C, 0, {1'b0, hi, lo, 3'h0, ch[4:0], 8'h00});
    slow <= 1'b1;
    apb(1, 8'h00, 32'h401, 0);
    f = {rbcd(), rbcd(), rbcd(), rbcd()};
    want('{8'hFE, 8'hFE, 8'h00, 8'h04, 8'h00, f[7:0], f[15:8], f[23:16],
           f[31:24], 8'hFD});
    want('{8'hFE, 8'hFE, 8'h00, 8'h04, 8'h01, 8'h05, 8'hFD});
    apb(1, 8'h04, f, 0);
    apb(1, 8'h08, 32'h5, 0);
    f = {rbcd(), rbcd(), rbcd(), rbcd()};
    cmd(8'h00, 8'h07, '{8'h00, f[7:0], f[15:8], f[23:16], f[31:24]});
    cmd(8'h00, 8'h07, '{8'h01, 8'h03});
    apb(0, 8'h04, 0, {1'b0, f});
    apb(0, 8'h08, 0, 33'h3);
    ack(8'hFB);
    want('{8'hFE, 8'hFE, 8'h00, 8'h04, 8'h01, 8'h01, 8'hFD});
    cmd(8'h04, 8'hE0, '{8'h06, 8'h01});
    apb(0, 8'h08, 0, 33'h1);
    cmp(33'(sci_host_model_i.lost), 33'h0);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
